// *** src/mbsd_ctrl.sv ***
// Purpose: MAC control word: back-off, duplex, speed and soft reset.
// Assumes: Strobe port master, loader presenting the chosen NV image.
// Notes: Auto detection inputs come from pins and are synchronised here.
`timescale 1ns/100ps
module mbsd_ctrl #(
    parameter int RETRY_WIDTH = 5,
    parameter int SPEED_WINDOW = mbsd_pkg::SPEED_WINDOW_CYC
)
(
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic [11:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    input wire logic usb_reset,
    input wire logic soft_lite_reset,
    input wire logic rst_protect,
    input wire logic nv_load,
    input wire logic nv_eeprom_present,
    input wire logic nv_otp_programmed,
    input wire logic nv_duplex,
    input wire logic [1:0] nv_speed,
    input wire logic nv_auto_duplex_flag,
    input wire logic nv_auto_speed_flag,
    input wire logic phy_duplex_pin,
    input wire logic rx_clk_sense,
    input wire logic collision,
    input wire logic [RETRY_WIDTH-1:0] retry_count,
    output logic backoff_busy,
    output logic retry_go,
    output logic mac_soft_reset,
    output logic mac_full_duplex,
    output logic [1:0] mac_speed,
    output logic gmii_select,
    output logic auto_duplex_on,
    output logic auto_speed_on
);

    typedef enum logic [0:0] {BO_IDLE, BO_WAIT} mbsd_bo_e;

    function automatic logic [3:0] limit_cap(input logic [1:0] sel);
        case (sel)
            2'h0: limit_cap = mbsd_pkg::CAP_LIMIT_0;
            2'h1: limit_cap = mbsd_pkg::CAP_LIMIT_1;
            2'h2: limit_cap = mbsd_pkg::CAP_LIMIT_2;
            default: limit_cap = mbsd_pkg::CAP_LIMIT_3;
        endcase
    endfunction : limit_cap

    function automatic logic [3:0] min4(input logic [3:0] a, input logic [3:0] b);
        min4 = (a < b) ? a : b;
    endfunction : min4

    function automatic logic is_gig(input logic [1:0] spd);
        is_gig = spd[1];
    endfunction : is_gig

    // Configuration state
    logic [1:0] backoff_limit;
    logic duplex_select;
    logic [1:0] speed_select;
    logic auto_duplex_detect;
    logic auto_speed_detect;

    // Image last loaded from EEPROM or OTP
    logic img_duplex;
    logic [1:0] img_speed;
    logic img_auto_duplex;
    logic img_auto_speed;

    // Last detected link state
    logic det_duplex;
    logic [1:0] det_speed;

    // Pin synchronisers
    logic dpx_meta;
    logic dpx_sync;
    logic rxc_meta;
    logic rxc_sync;
    logic rxc_prev;

    // Speed measurement
    logic [15:0] win_cnt;
    logic [15:0] edge_cnt;
    logic rxc_rise;
    logic win_end;
    logic [1:0] meas_speed;

    // Back-off engine
    mbsd_bo_e bo_state;
    logic [9:0] bo_remain;
    logic [11:0] slot_cnt;
    logic [9:0] lfsr_value;
    logic [3:0] retry_clip;
    logic [3:0] exp_k;
    logic [3:0] use_bits;
    logic [9:0] use_mask;
    logic [9:0] draw;
    logic [11:0] slot_len;
    logic slot_done;

    // Bus decode and resets
    logic hit;
    logic wr_hit;
    logic rd_hit;
    logic field_reset;
    logic [31:0] read_word;
    logic [1:0] eff_speed;
    logic eff_duplex;
    logic [1:0] next_speed_src;

    mbsd_lfsr #(
        .WIDTH(mbsd_pkg::LFSR_WIDTH),
        .SEED(mbsd_pkg::LFSR_SEED)
    ) u_lfsr (
        .core_clk(core_clk),
        .sys_rst(sys_rst),
        .lfsr_value(lfsr_value)
    );

    assign hit = (reg_addr == mbsd_pkg::MAC_CONTROL_ADDR);
    assign wr_hit = reg_wr & hit;
    assign rd_hit = reg_rd & hit;
    assign field_reset = usb_reset | soft_lite_reset;

    // Pin synchronisers: first stage feeds only the second
    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            dpx_meta <= 1'b0;
            dpx_sync <= 1'b0;
            rxc_meta <= 1'b0;
            rxc_sync <= 1'b0;
            rxc_prev <= 1'b0;
        end
        else
        begin
            dpx_meta <= phy_duplex_pin;
            dpx_sync <= dpx_meta;
            rxc_meta <= rx_clk_sense;
            rxc_sync <= rxc_meta;
            rxc_prev <= rxc_sync;
        end
    end

    localparam logic [1:0] MBSD_SPEED_10_C = mbsd_pkg::MBSD_SPEED_10;
    localparam logic [1:0] MBSD_SPEED_100_C = mbsd_pkg::MBSD_SPEED_100;
    localparam logic [1:0] MBSD_SPEED_1000_C = mbsd_pkg::MBSD_SPEED_1000;

    // Speed from receive clock edges per window
    assign rxc_rise = rxc_sync & ~rxc_prev;
    assign win_end = (win_cnt == 16'(SPEED_WINDOW - 1));
    assign meas_speed = (edge_cnt >= 16'(mbsd_pkg::SPEED_EDGES_1000)) ? MBSD_SPEED_1000_C :
                        (edge_cnt >= 16'(mbsd_pkg::SPEED_EDGES_100)) ? MBSD_SPEED_100_C :
                        MBSD_SPEED_10_C;

    always_ff @(posedge core_clk)
    begin
        if (sys_rst | win_end)
        begin
            win_cnt <= 16'h0000;
            edge_cnt <= 16'h0000;
        end
        else
        begin
            win_cnt <= win_cnt + 16'h0001;
            if (rxc_rise && edge_cnt != 16'hffff)
                edge_cnt <= edge_cnt + 16'h0001;
        end
    end

    // Detected values are only refreshed while detection is on
    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            det_duplex <= mbsd_pkg::DUPLEX_RESET;
            det_speed <= mbsd_pkg::SPEED_RESET;
        end
        else
        begin
            if (auto_duplex_detect)
                det_duplex <= dpx_sync;
            if (auto_speed_detect && win_end)
                det_speed <= meas_speed;
        end
    end

    // Image capture; the EEPROM or OTP image the loader presents beats hard defaults
    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            img_duplex <= mbsd_pkg::DUPLEX_RESET;
            img_speed <= mbsd_pkg::SPEED_RESET;
            img_auto_duplex <= mbsd_pkg::AUTO_DUPLEX_RESET;
            img_auto_speed <= mbsd_pkg::AUTO_SPEED_RESET;
        end
        else if (nv_load)
        begin
            if (nv_eeprom_present | nv_otp_programmed)
            begin
                img_duplex <= nv_duplex;
                img_speed <= nv_speed;
                img_auto_duplex <= nv_auto_duplex_flag;
                img_auto_speed <= nv_auto_speed_flag;
            end
            else
            begin
                img_duplex <= mbsd_pkg::DUPLEX_RESET;
                img_speed <= mbsd_pkg::SPEED_RESET;
                img_auto_duplex <= mbsd_pkg::AUTO_DUPLEX_RESET;
                img_auto_speed <= mbsd_pkg::AUTO_SPEED_RESET;
            end
        end
    end

    // The source of a reload: a fresh image wins over the stored one
    assign next_speed_src = nv_load ?
        ((nv_eeprom_present | nv_otp_programmed) ? nv_speed : mbsd_pkg::SPEED_RESET) :
        img_speed;

    // Control fields
    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            backoff_limit <= mbsd_pkg::BACKOFF_LIMIT_RESET;
            duplex_select <= mbsd_pkg::DUPLEX_RESET;
            speed_select <= mbsd_pkg::SPEED_RESET;
            auto_duplex_detect <= mbsd_pkg::AUTO_DUPLEX_RESET;
            auto_speed_detect <= mbsd_pkg::AUTO_SPEED_RESET;
        end
        else if (nv_load)
        begin
            duplex_select <= (nv_eeprom_present | nv_otp_programmed) ?
                             nv_duplex : mbsd_pkg::DUPLEX_RESET;
            speed_select <= next_speed_src;
            auto_duplex_detect <= (nv_eeprom_present | nv_otp_programmed) ?
                                  nv_auto_duplex_flag : mbsd_pkg::AUTO_DUPLEX_RESET;
            auto_speed_detect <= (nv_eeprom_present | nv_otp_programmed) ?
                                 nv_auto_speed_flag : mbsd_pkg::AUTO_SPEED_RESET;
        end
        else if (field_reset)
        begin
            // Protected resets keep the link mode software chose
            if (!rst_protect)
            begin
                duplex_select <= img_duplex;
                speed_select <= img_speed;
            end
            auto_duplex_detect <= img_auto_duplex;
            auto_speed_detect <= img_auto_speed;
            backoff_limit <= mbsd_pkg::BACKOFF_LIMIT_RESET;
        end
        else if (wr_hit)
        begin
            backoff_limit <= reg_wdata[mbsd_pkg::BIT_BACKOFF_LO +: 2];
            auto_duplex_detect <= reg_wdata[mbsd_pkg::BIT_AUTO_DUPLEX];
            auto_speed_detect <= reg_wdata[mbsd_pkg::BIT_AUTO_SPEED];
            if (!auto_duplex_detect)
                duplex_select <= reg_wdata[mbsd_pkg::BIT_DUPLEX];
            if (!auto_speed_detect)
                speed_select <= reg_wdata[mbsd_pkg::BIT_SPEED_LO +: 2];
        end
    end

    // Self-clearing MAC reset, one cycle wide
    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
            mac_soft_reset <= 1'b0;
        else
            mac_soft_reset <= wr_hit & reg_wdata[mbsd_pkg::BIT_SOFT_RESET];
    end

    // Operating mode seen by the MAC datapath
    assign eff_speed = auto_speed_detect ? det_speed : speed_select;
    // Gigabit forces full duplex whatever bit 3 says
    assign eff_duplex = (auto_duplex_detect ? det_duplex : duplex_select)
                        | is_gig(eff_speed);

    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            mac_full_duplex <= mbsd_pkg::DUPLEX_RESET;
            mac_speed <= mbsd_pkg::SPEED_RESET;
            gmii_select <= 1'b0;
        end
        else
        begin
            mac_full_duplex <= eff_duplex;
            mac_speed <= eff_speed;
            gmii_select <= is_gig(eff_speed);
        end
    end

    assign auto_duplex_on = auto_duplex_detect;
    assign auto_speed_on = auto_speed_detect;

    // Back-off draw
    assign retry_clip = (retry_count > RETRY_WIDTH'(mbsd_pkg::EXP_CEILING)) ?
                        mbsd_pkg::EXP_CEILING : 4'(retry_count);
    assign exp_k = min4(retry_clip, mbsd_pkg::EXP_CEILING);
    assign use_bits = min4(exp_k, limit_cap(backoff_limit));
    assign use_mask = 10'((11'h001 << use_bits) - 11'h001);
    assign draw = lfsr_value & use_mask;

    // Slot length tracks the operating speed
    assign slot_len = is_gig(eff_speed) ? 12'(mbsd_pkg::SLOT_1000_CYC) :
                      eff_speed[0] ? 12'(mbsd_pkg::SLOT_100_CYC) :
                      12'(mbsd_pkg::SLOT_10_CYC);
    assign slot_done = (slot_cnt == slot_len - 12'h001);

    always_ff @(posedge core_clk)
    begin
        if (sys_rst | mac_soft_reset)
        begin
            bo_state <= BO_IDLE;
            bo_remain <= 10'h000;
            slot_cnt <= 12'h000;
            retry_go <= 1'b0;
        end
        else
        begin
            retry_go <= 1'b0;
            unique case (bo_state)
                BO_IDLE:
                begin
                    slot_cnt <= 12'h000;
                    if (collision)
                    begin
                        // A zero draw retries at once
                        if (draw == 10'h000)
                            retry_go <= 1'b1;
                        else
                        begin
                            bo_remain <= draw;
                            bo_state <= BO_WAIT;
                        end
                    end
                end
                BO_WAIT:
                begin
                    if (slot_done)
                    begin
                        slot_cnt <= 12'h000;
                        bo_remain <= bo_remain - 10'h001;
                        if (bo_remain == 10'h001)
                        begin
                            retry_go <= 1'b1;
                            bo_state <= BO_IDLE;
                        end
                    end
                    else
                        slot_cnt <= slot_cnt + 12'h001;
                end
            endcase
        end
    end

    assign backoff_busy = (bo_state == BO_WAIT);

    // Read view; writes to a field in auto mode leave it alone
    always_comb
    begin
        read_word = 32'h0000_0000;
        read_word[mbsd_pkg::BIT_AUTO_DUPLEX] = auto_duplex_detect;
        read_word[mbsd_pkg::BIT_AUTO_SPEED] = auto_speed_detect;
        read_word[mbsd_pkg::BIT_BACKOFF_LO +: 2] = backoff_limit;
        read_word[mbsd_pkg::BIT_DUPLEX] = auto_duplex_detect ?
                                          det_duplex : duplex_select;
        read_word[mbsd_pkg::BIT_SPEED_LO +: 2] = auto_speed_detect ?
                                                 det_speed : speed_select;
        read_word[mbsd_pkg::BIT_SOFT_RESET] = 1'b0;
    end

    // Unmapped reads return zero; data only in the cycle after the strobe
    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
            reg_rdata <= 32'h0000_0000;
        else if (rd_hit)
            reg_rdata <= read_word;
        else
            reg_rdata <= 32'h0000_0000;
    end

endmodule : mbsd_ctrl

// *** inc/mbsd_pkg.sv ***
// Purpose: Constants for the MAC back-off, speed and duplex control block.
// Assumes: 50 MHz core clock, one register word on a plain strobe port.
// Notes: Field positions follow the lower half of the MAC control word.
package mbsd_pkg;

    localparam logic [11:0] MAC_CONTROL_ADDR = 12'h100;

    localparam int BIT_SOFT_RESET = 0;
    localparam int BIT_SPEED_LO = 1;
    localparam int BIT_DUPLEX = 3;
    localparam int BIT_BACKOFF_LO = 6;
    localparam int BIT_AUTO_SPEED = 11;
    localparam int BIT_AUTO_DUPLEX = 12;

    localparam logic [1:0] BACKOFF_LIMIT_RESET = 2'h0;
    localparam logic DUPLEX_RESET = 1'b0;
    localparam logic [1:0] SPEED_RESET = 2'h0;
    localparam logic AUTO_DUPLEX_RESET = 1'b1;
    localparam logic AUTO_SPEED_RESET = 1'b0;

    typedef enum logic [1:0]
    {
        MBSD_SPEED_10 = 2'h0,
        MBSD_SPEED_100 = 2'h1,
        MBSD_SPEED_1000 = 2'h2
    } mbsd_speed_e;

    localparam logic [3:0] EXP_CEILING = 4'ha;
    localparam logic [3:0] CAP_LIMIT_0 = 4'ha;
    localparam logic [3:0] CAP_LIMIT_1 = 4'h8;
    localparam logic [3:0] CAP_LIMIT_2 = 4'h4;
    localparam logic [3:0] CAP_LIMIT_3 = 4'h1;

    localparam int CLK_PERIOD_NS = 20;
    localparam int SLOT_10_NS = 51200;
    localparam int SLOT_100_NS = 5120;
    localparam int SLOT_1000_NS = 4096;
    // Least times, so round up
    localparam int SLOT_10_CYC = (SLOT_10_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SLOT_100_CYC = (SLOT_100_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SLOT_1000_CYC = (SLOT_1000_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    localparam int SPEED_WINDOW_CYC = 256;
    localparam int SPEED_EDGES_100 = 4;
    localparam int SPEED_EDGES_1000 = 20;

    localparam int LFSR_WIDTH = 10;
    localparam logic [9:0] LFSR_SEED = 10'h2a5;

endpackage : mbsd_pkg

// *** src/mbsd_lfsr.sv ***
// Purpose: Free-running Fibonacci LFSR used as the back-off random source.
// Assumes: Width of 10 with taps at 10 and 7, a maximal-length sequence.
// Notes: The all-zero state is locked out by the nonzero seed.
`timescale 1ns/100ps
module mbsd_lfsr #(
    parameter int WIDTH = 10,
    parameter logic [WIDTH-1:0] SEED = 10'h2a5
)
(
    input wire logic core_clk,
    input wire logic sys_rst,
    output logic [WIDTH-1:0] lfsr_value
);

    logic feedback;

    // Taps fit the default width; other widths need their own taps
    assign feedback = lfsr_value[WIDTH-1] ^ lfsr_value[WIDTH-4];

    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
            lfsr_value <= SEED;
        else
            lfsr_value <= {lfsr_value[WIDTH-2:0], feedback};
    end

endmodule : mbsd_lfsr

// *** bench/mbsd_ctrl_chk.sv ***
// Purpose: Port-level checks on the MAC back-off, speed and duplex control.
// Assumes: One clock domain; sys_rst is synchronous and active high.
// Notes: Bound onto every mbsd_ctrl instance.
`timescale 1ns/100ps
module mbsd_ctrl_chk #(
    parameter int RETRY_WIDTH = 5
)
(
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic [11:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [31:0] reg_rdata,
    input wire logic usb_reset,
    input wire logic soft_lite_reset,
    input wire logic nv_load,
    input wire logic phy_duplex_pin,
    input wire logic collision,
    input wire logic [RETRY_WIDTH-1:0] retry_count,
    input wire logic backoff_busy,
    input wire logic retry_go,
    input wire logic mac_soft_reset,
    input wire logic mac_full_duplex,
    input wire logic [1:0] mac_speed,
    input wire logic gmii_select,
    input wire logic auto_duplex_on,
    input wire logic auto_speed_on
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (sys_rst);
    wire ctrl_hit = reg_addr == mbsd_pkg::MAC_CONTROL_ADDR;
    // A following write or a restore in the write cycle could overwrite the field, so exclude them
    sequence manual_write;
        reg_wr && ctrl_hit && !auto_duplex_on && !auto_speed_on && !reg_wdata[2]
            && (reg_wdata[12:11] == 2'h0) && !reg_wdata[0]
            && !nv_load && !usb_reset && !soft_lite_reset ##1 !reg_wr;
    endsequence
    // Pin must outlast the two-stage synchroniser and detect register
    sequence duplex_settled;
        (auto_duplex_on && $stable(phy_duplex_pin)) [*6] ##0 (reg_rd && ctrl_hit);
    endsequence
    AST_RDATA_IDLE: assert property (reg_rdata != 32'h0 |-> $past(reg_rd && ctrl_hit))
        else $error("read data outside a read answer");
    AST_RDATA_ZEROS: assert property (
        reg_rd && ctrl_hit |=> (reg_rdata & 32'hffffe731) == 32'h0)
        else $error("reserved or self-clearing bits read nonzero");
    AST_SOFT_PULSE: assert property (
        reg_wr && ctrl_hit && reg_wdata[0] |=> mac_soft_reset ##1 !mac_soft_reset)
        else $error("soft reset pulse missing or too long");
    AST_SOFT_CAUSE: assert property (
        mac_soft_reset |-> $past(reg_wr && ctrl_hit && reg_wdata[0]))
        else $error("soft reset without a write of one");
    AST_GIGA_FULL: assert property (gmii_select |-> mac_full_duplex)
        else $error("half duplex at gigabit");
    AST_GMII_SPEED: assert property (gmii_select == mac_speed[1])
        else $error("gmii select disagrees with speed");
    AST_MANUAL_FIELDS: assert property (
        manual_write |=> mac_full_duplex == $past(reg_wdata[3], 2)
        && mac_speed == $past(reg_wdata[2:1], 2))
        else $error("manual duplex or speed not applied");
    AST_AUTO_DUPLEX_READ: assert property (
        duplex_settled |=> reg_rdata[3] == $past(phy_duplex_pin))
        else $error("duplex readback not the detected mode");
    AST_NO_WAIT: assert property (
        collision && !backoff_busy && retry_count == '0 |=> retry_go)
        else $error("zero exponent did not retry at once");
    AST_BUSY_CAUSE: assert property ($rose(backoff_busy) |-> $past(collision))
        else $error("back-off started without a collision");
    AST_RETRY_ONCE: assert property (retry_go |-> !backoff_busy && !$past(retry_go))
        else $error("retry pulse longer than one cycle or while busy");
endmodule : mbsd_ctrl_chk

bind mbsd_ctrl mbsd_ctrl_chk #(.RETRY_WIDTH(RETRY_WIDTH)) u_chk (
    .core_clk(core_clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .usb_reset(usb_reset),
    .soft_lite_reset(soft_lite_reset), .nv_load(nv_load), .phy_duplex_pin(phy_duplex_pin),
    .collision(collision), .retry_count(retry_count), .backoff_busy(backoff_busy),
    .retry_go(retry_go), .mac_soft_reset(mac_soft_reset), .mac_full_duplex(mac_full_duplex),
    .mac_speed(mac_speed), .gmii_select(gmii_select), .auto_duplex_on(auto_duplex_on),
    .auto_speed_on(auto_speed_on)
);

// *** bench/mbsd_phy_model.sv ***
// Purpose: PHY side of the MAC: duplex pin and divided receive clock.
// Assumes: Sense pin is the receive clock divided by 16.
// Notes: A half period of zero stops the clock, holding its last level.
`timescale 1ns/100ps
module mbsd_phy_model (
    input wire logic full_duplex,
    input wire logic [15:0] half_ns,
    output logic phy_duplex_pin,
    output logic rx_clk_sense
);
    assign phy_duplex_pin = full_duplex;
    initial
    begin
        rx_clk_sense = 1'b0;
        forever
        begin
            if (half_ns == 16'h0)
                #10;
            else
            begin
                #(half_ns);
                rx_clk_sense = ~rx_clk_sense;
            end
        end
    end
endmodule : mbsd_phy_model

// *** bench/mbsd_ctrl_test.sv ***
// Purpose: Self-checking bench for the MAC back-off, speed and duplex control.
// Assumes: Inputs change by non-blocking assignment at the rising edge.
// Notes: Back-off runs at gigabit with small exponents to keep waits short.
`timescale 1ns/100ps
module mbsd_ctrl_test;
    localparam logic [11:0] CA = mbsd_pkg::MAC_CONTROL_ADDR;
    localparam int SLOT = mbsd_pkg::SLOT_1000_CYC;
    logic core_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic [11:0] reg_addr = 12'h0;
    logic [31:0] reg_wdata = 32'h0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [2:0] pulses = 3'h0;
    logic rst_protect = 1'b0;
    logic [6:0] img = 7'h0;
    logic collision = 1'b0;
    logic [4:0] retry_count = 5'h0;
    logic dup_pin = 1'b0;
    logic [15:0] half_ns = 16'h0;
    logic phy_duplex_pin, rx_clk_sense, backoff_busy, retry_go, mac_soft_reset;
    logic mac_full_duplex, gmii_select, auto_duplex_on, auto_speed_on;
    logic [1:0] mac_speed;
    logic [31:0] reg_rdata;
    logic rd_d = 1'b0;
    logic [31:0] exp_q [$];
    int errors = 0;
    int checks = 0;
    int cap [4] = '{10, 8, 4, 1};

    mbsd_ctrl dut (.core_clk(core_clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .usb_reset(pulses[1]), .soft_lite_reset(pulses[2]), .rst_protect(rst_protect),
        .nv_load(pulses[0]), .nv_eeprom_present(img[6]), .nv_otp_programmed(img[5]),
        .nv_duplex(img[4]), .nv_speed(img[3:2]), .nv_auto_duplex_flag(img[1]),
        .nv_auto_speed_flag(img[0]), .phy_duplex_pin(phy_duplex_pin),
        .rx_clk_sense(rx_clk_sense), .collision(collision), .retry_count(retry_count),
        .backoff_busy(backoff_busy), .retry_go(retry_go), .mac_soft_reset(mac_soft_reset),
        .mac_full_duplex(mac_full_duplex), .mac_speed(mac_speed), .gmii_select(gmii_select),
        .auto_duplex_on(auto_duplex_on), .auto_speed_on(auto_speed_on));
    mbsd_phy_model phy (.full_duplex(dup_pin), .half_ns(half_ns),
        .phy_duplex_pin(phy_duplex_pin), .rx_clk_sense(rx_clk_sense));

    initial
    begin
        forever #10 core_clk = ~core_clk;
    end

    task automatic conclude();
        $display("errors=%0d checks=%0d", errors, checks);
        if (errors == 0 && checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : conclude

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
        checks++;
        if (got !== exp)
        begin
            errors++;
            $display("mismatch at %0t: %s got %h want %h", $time, msg, got, exp);
        end
    endtask : chk

    task automatic tick(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask : tick

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge core_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask : wr

    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        @(posedge core_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        exp_q.push_back(e);
        @(posedge core_clk);
        reg_rd <= 1'b0;
    endtask : rd

    // Image fields: eeprom, otp, duplex, speed, auto duplex flag, auto speed flag
    task automatic pulse(input int i, input logic [6:0] v);
        @(posedge core_clk);
        img <= v;
        pulses[i] <= 1'b1;
        @(posedge core_clk);
        pulses <= 3'h0;
        tick(6);
    endtask : pulse

    task automatic backoff(input logic [1:0] lim, input logic [4:0] n);
        int k;
        int cnt;
        int ok;
        k = (n > 10) ? 10 : n;
        if (k > cap[lim])
            k = cap[lim];
        wr(CA, 32'h4 | (32'(lim) << 6));
        @(posedge core_clk);
        collision <= 1'b1;
        retry_count <= n;
        @(posedge core_clk);
        collision <= 1'b0;
        #1;
        cnt = 1;
        while (retry_go !== 1'b1 && cnt < 4000)
        begin
            tick(1);
            cnt++;
        end
        // Whole slots only, and fewer than two to the K of them
        ok = ((cnt - 1) % SLOT == 0) && ((cnt - 1) / SLOT < (1 << k));
        chk(32'(ok), 32'h1, "backoff");
    endtask : backoff

    always @(posedge core_clk)
    begin
        if (rd_d)
            chk(reg_rdata, exp_q.pop_front(), "read data");
        rd_d <= reg_rd;
    end

    initial
    begin
        #2_000_000;
        errors++;
        conclude();
    end

    initial
    begin
        int w;
        int s;
        void'($urandom(23));
        repeat (10) @(posedge core_clk);
        sys_rst <= 1'b0;
        rd(CA, 32'h1000);
        chk(32'({auto_duplex_on, auto_speed_on}), 32'h2, "auto enables at reset");
        rd(12'h104, 32'h0);
        dup_pin <= 1'b1;
        tick(8);
        wr(CA, 32'h1000);
        rd(CA, 32'h1008);
        wr(CA, 32'h0);
        for (int i = 0; i < 6; i++)
        begin
            s = i / 2;
            w = 32'h80 | ((i % 2) << 3) | (s << 1);
            wr(CA, w);
            tick(2);
            chk(32'(mac_speed), s, "speed out");
            chk(32'(mac_full_duplex), (i % 2) | (s == 2), "duplex out");
            chk(32'(gmii_select), s == 2, "gmii select");
            rd(CA, w);
        end
        wr(CA, 32'h1);
        #1;
        chk(32'(mac_soft_reset), 1, "soft reset high");
        tick(1);
        chk(32'(mac_soft_reset), 0, "soft reset low");
        rd(CA, 32'h0);
        for (int i = 0; i < 12; i++)
        begin
            s = i / 3;
            w = (s < 2) ? $urandom % (s + 4) : 4 + $urandom % 9;
            backoff(s, (i == 0) ? 5'h0 : 5'(w));
        end
        wr(CA, 32'h0);
        pulse(0, 7'h54);
        rd(CA, 32'ha);
        wr(CA, 32'h0);
        pulse(1, 7'h54);
        rd(CA, 32'ha);
        wr(CA, 32'h0);
        rst_protect <= 1'b1;
        pulse(2, 7'h54);
        rd(CA, 32'h0);
        rst_protect <= 1'b0;
        pulse(0, 7'h28);
        rd(CA, 32'h4);
        pulse(0, 7'h7f);
        rd(CA, 32'h1808);
        chk(32'({auto_duplex_on, auto_speed_on}), 32'h3, "auto enables loaded");
        wr(CA, 32'h800);
        half_ns <= 16'd64;
        tick(600);
        rd(CA, 32'h80c);
        chk(32'(gmii_select), 1, "detected gigabit");
        half_ns <= 16'd320;
        tick(600);
        wr(CA, 32'h800);
        rd(CA, 32'h802);
        half_ns <= 16'h0;
        tick(4);
        conclude();
    end
endmodule : mbsd_ctrl_test
